/* File: rtl/mssr_regs.sv */
`timescale 1ns/1ps
module mssr_regs
  import mssr_pkg::*;
#(
  parameter int WDT_SHORT = WDT_SHORT_CYC,
  parameter int WDT_LONG = WDT_LONG_CYC,
  parameter int S0S1_HOLD = S0S1_HOLD_CYC,
  parameter bit EARLY_REV = 1'b0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register access from bus controller
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // power unit state
  input wire logic [3:0] i_eff_odr,
  input wire logic [1:0] i_eff_avg,
  // bus error events
  input wire logic i_parity_err,
  input wire logic i_s0s1_err,
  input wire logic i_hdr_exit,
  // watchdog
  input wire logic i_bus_stall,
  output logic o_wdt_timeout,
  // data ready and in-band interrupt
  input wire logic i_drdy_event,
  input wire logic i_ibi_done,
  output logic o_ibi_req,
  // interrupt pin
  output logic o_int_out,
  output logic o_int_oe
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] wdt_cfg_q;
  logic [7:0] pin_cfg_q;
  logic [7:0] ibi_cfg_q;
  logic err_par_q;
  logic err_s0s1_q;
  logic drdy_q;
  logic ibi_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] wdt_cnt_q;
  logic [2:0] pulse_cnt_q;
  logic wr_err;
  logic rd_err;
  logic wr_stat;
  logic rd_stat;
  logic drdy_set;
  logic [CNT_W-1:0] wdt_lim;
  logic out_en;
  logic active;
  logic level;

  function automatic logic hit(input logic en, input logic [7:0] ofs);
    hit = en && (i_reg_addr == ofs);
  endfunction

  assign wr_err = hit(i_reg_wr, OFS_BUS_ERROR_FLAGS);
  assign rd_err = hit(i_reg_rd, OFS_BUS_ERROR_FLAGS);
  assign wr_stat = hit(i_reg_wr, OFS_IRQ_STATUS);
  assign rd_stat = hit(i_reg_rd, OFS_IRQ_STATUS);
  assign drdy_set = i_drdy_event && pin_cfg_q[BIT_DRDY_EN];

  ////////////////////////////////////////////////////////////////////////////
  // configuration bytes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wdt_cfg_q <= RST_BYTE[1:0];
      pin_cfg_q <= RST_BYTE;
      ibi_cfg_q <= RST_BYTE;
    end else begin
      if (hit(i_reg_wr, OFS_BUS_WDT_CONFIG)) begin
        wdt_cfg_q <= i_reg_wdata[1:0] & MASK_WDT[1:0];
      end
      if (hit(i_reg_wr, OFS_IRQ_PIN_CONFIG)) begin
        pin_cfg_q <= i_reg_wdata & MASK_IRQ_PIN;
      end
      if (hit(i_reg_wr, OFS_INBAND_IRQ_CONFIG)) begin
        ibi_cfg_q <= i_reg_wdata & MASK_INBAND;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= RST_BYTE;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        OFS_RATE_AVG_STATUS: begin
          o_reg_rdata <= {2'h0, i_eff_avg, i_eff_odr};
        end
        OFS_BUS_ERROR_FLAGS: begin
          o_reg_rdata <= RST_BYTE;
          o_reg_rdata[BIT_ERR_PARITY] <= err_par_q;
          o_reg_rdata[BIT_ERR_S0S1] <= err_s0s1_q;
        end
        OFS_BUS_WDT_CONFIG: o_reg_rdata <= {6'h00, wdt_cfg_q};
        // earliest revision shows the output gate as reserved
        OFS_IRQ_PIN_CONFIG: begin
          o_reg_rdata <= pin_cfg_q;
          if (EARLY_REV) begin
            o_reg_rdata[BIT_OUT_EN] <= 1'b0;
          end
        end
        OFS_INBAND_IRQ_CONFIG: o_reg_rdata <= ibi_cfg_q;
        OFS_IRQ_STATUS: begin
          o_reg_rdata <= RST_BYTE;
          o_reg_rdata[BIT_DRDY] <= drdy_q;
        end
        default: o_reg_rdata <= RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus error flags; a new event always beats a clear
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      err_par_q <= 1'b0;
    end else if (i_parity_err) begin
      err_par_q <= 1'b1;
    end else if (rd_err) begin
      err_par_q <= 1'b0;
    end else if (wr_err && i_reg_wdata[BIT_ERR_PARITY]) begin
      err_par_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      err_s0s1_q <= 1'b0;
      hold_cnt_q <= '0;
    end else if (i_s0s1_err) begin
      err_s0s1_q <= 1'b1;
      hold_cnt_q <= '0;
    end else if (err_s0s1_q) begin
      hold_cnt_q <= hold_cnt_q + CNT_W'(1);
      if (i_hdr_exit || hold_cnt_q == CNT_W'(S0S1_HOLD - 1)) begin
        err_s0s1_q <= 1'b0;
      end else if (rd_err) begin
        err_s0s1_q <= 1'b0;
      end else if (wr_err && i_reg_wdata[BIT_ERR_S0S1]) begin
        err_s0s1_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: runs only while the bus is held in a stalled state
  assign wdt_lim = wdt_cfg_q[BIT_WDT_SEL] ? CNT_W'(WDT_LONG - 1)
                                          : CNT_W'(WDT_SHORT - 1);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wdt_cnt_q <= '0;
      o_wdt_timeout <= 1'b0;
    end else begin
      o_wdt_timeout <= 1'b0;
      if (!wdt_cfg_q[BIT_WDT_EN] || !i_bus_stall) begin
        wdt_cnt_q <= '0;
      end else if (wdt_cnt_q >= wdt_lim) begin
        wdt_cnt_q <= '0;
        o_wdt_timeout <= 1'b1;
      end else begin
        wdt_cnt_q <= wdt_cnt_q + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data-ready status and in-band interrupt
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      drdy_q <= 1'b0;
    end else if (drdy_set) begin
      drdy_q <= 1'b1;
    end else if (rd_stat || (wr_stat && i_reg_wdata[BIT_DRDY])) begin
      drdy_q <= 1'b0;
    end else if (i_ibi_done && ibi_q && ibi_cfg_q[BIT_IBI_CLR]) begin
      drdy_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ibi_q <= 1'b0;
    end else if (drdy_set && ibi_cfg_q[BIT_IBI_MAP]) begin
      ibi_q <= 1'b1;
    end else if (i_ibi_done) begin
      ibi_q <= 1'b0;
    end
  end
  assign o_ibi_req = ibi_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pulse_cnt_q <= 3'h0;
    end else if (drdy_set) begin
      pulse_cnt_q <= PULSE_CYC;
    end else if (pulse_cnt_q != 3'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 3'h1;
    end
  end

  // the gate does not exist on the earliest revision, so it stays open
  assign out_en = EARLY_REV || pin_cfg_q[BIT_OUT_EN];
  assign active = out_en && (pin_cfg_q[BIT_MODE]
                             ? drdy_q : pulse_cnt_q != 3'h0);
  assign level = pin_cfg_q[BIT_POL] ? active : !active;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_int_out <= 1'b0;
      o_int_oe <= 1'b0;
    end else if (pin_cfg_q[BIT_DRV]) begin
      o_int_out <= level;
      o_int_oe <= 1'b1;
    end else begin
      o_int_out <= 1'b0;
      o_int_oe <= !level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_status_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      hit(i_reg_rd, OFS_RATE_AVG_STATUS) |=>
        o_reg_rdata == {2'h0, $past(i_eff_avg), $past(i_eff_odr)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("rate status byte wrong");

  property p_err_read_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
      rd_err && !i_parity_err && !i_s0s1_err |=> !err_par_q && !err_s0s1_q;
  endproperty
  a_err_read_clear: assert property (p_err_read_clear)
    else $error("error flags survive read");

  property p_err_w1c;
    @(posedge i_ref_clk) disable iff (i_rst)
      err_par_q && wr_err && !i_reg_wdata[BIT_ERR_PARITY] && !rd_err
        |=> err_par_q;
  endproperty
  a_err_w1c: assert property (p_err_w1c)
    else $error("write zero cleared flag");

  property p_parity_set;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_parity_err |=> err_par_q ##1 (err_par_q || $past(rd_err || wr_err));
  endproperty
  a_parity_set: assert property (p_parity_set)
    else $error("parity flag not set");

  property p_s0s1_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_s0s1_err && !i_hdr_exit |=> err_s0s1_q;
  endproperty
  a_s0s1_hold: assert property (p_s0s1_hold)
    else $error("s0s1 flag not set");

  property p_s0s1_hdr;
    @(posedge i_ref_clk) disable iff (i_rst)
      err_s0s1_q && i_hdr_exit && !i_s0s1_err |=> !err_s0s1_q;
  endproperty
  a_s0s1_hdr: assert property (p_s0s1_hdr)
    else $error("s0s1 flag not cleared by hdr exit");

  property p_wdt_off;
    @(posedge i_ref_clk) disable iff (i_rst)
      !wdt_cfg_q[BIT_WDT_EN] |=> !o_wdt_timeout;
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("timeout while watchdog disabled");

  property p_wdt_limit;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_wdt_timeout |-> $past(wdt_cnt_q) == $past(wdt_lim);
  endproperty
  a_wdt_limit: assert property (p_wdt_limit)
    else $error("timeout at wrong count");

  property p_latched_pin;
    @(posedge i_ref_clk) disable iff (i_rst)
      pin_cfg_q[BIT_MODE] && pin_cfg_q[BIT_DRV] && out_en && drdy_q
        && $stable(pin_cfg_q) |=> o_int_out == pin_cfg_q[BIT_POL];
  endproperty
  a_latched_pin: assert property (p_latched_pin)
    else $error("latched pin not active");

  property p_od_drive;
    @(posedge i_ref_clk) disable iff (i_rst)
      !pin_cfg_q[BIT_DRV] |=> !o_int_out;
  endproperty
  a_od_drive: assert property (p_od_drive)
    else $error("open drain drove high");

  property p_pulse_width;
    @(posedge i_ref_clk) disable iff (i_rst)
      drdy_set |=> (pulse_cnt_q != 3'h0 || drdy_set) [*4];
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulse too short");

  property p_drdy_gate;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_drdy_event && !pin_cfg_q[BIT_DRDY_EN] && !drdy_q |=> !drdy_q;
  endproperty
  a_drdy_gate: assert property (p_drdy_gate)
    else $error("disabled data-ready set flag");

  property p_ibi_req;
    @(posedge i_ref_clk) disable iff (i_rst)
      drdy_set && ibi_cfg_q[BIT_IBI_MAP] |=> o_ibi_req;
  endproperty
  a_ibi_req: assert property (p_ibi_req)
    else $error("in-band request missing");

  property p_ibi_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
      ibi_q && i_ibi_done && ibi_cfg_q[BIT_IBI_CLR] && !drdy_set |=> !drdy_q;
  endproperty
  a_ibi_clear: assert property (p_ibi_clear)
    else $error("auto clear missing");

  property p_stat_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      rd_stat && !drdy_set |=> !drdy_q;
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status not cleared on read");

endmodule

/* File: rtl/mssr_pkg.sv */
package mssr_pkg;
  // register offsets
  localparam logic [7:0] OFS_RATE_AVG_STATUS = 8'h08;
  localparam logic [7:0] OFS_BUS_ERROR_FLAGS = 8'h09;
  localparam logic [7:0] OFS_BUS_WDT_CONFIG = 8'h0A;
  localparam logic [7:0] OFS_IRQ_PIN_CONFIG = 8'h2E;
  localparam logic [7:0] OFS_INBAND_IRQ_CONFIG = 8'h2F;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // field positions
  localparam int BIT_AVG_LO = 4;
  localparam int BIT_ERR_PARITY = 0;
  localparam int BIT_ERR_S0S1 = 3;
  localparam int BIT_WDT_EN = 0;
  localparam int BIT_WDT_SEL = 1;
  localparam int BIT_MODE = 0;
  localparam int BIT_POL = 1;
  localparam int BIT_DRV = 2;
  localparam int BIT_OUT_EN = 4;
  localparam int BIT_DRDY_EN = 7;
  localparam int BIT_IBI_MAP = 0;
  localparam int BIT_IBI_CLR = 4;
  localparam int BIT_DRDY = 2;
  // writable bits
  localparam logic [7:0] MASK_WDT = 8'h03;
  localparam logic [7:0] MASK_IRQ_PIN = 8'h97;
  localparam logic [7:0] MASK_INBAND = 8'h11;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_SHORT_NS = 1280000;
  localparam int WDT_LONG_NS = 40960000;
  localparam int S0S1_HOLD_NS = 60000;
  localparam int WDT_SHORT_CYC = WDT_SHORT_NS / CLK_PERIOD_NS;
  localparam int WDT_LONG_CYC = WDT_LONG_NS / CLK_PERIOD_NS;
  localparam int S0S1_HOLD_CYC = S0S1_HOLD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] PULSE_CYC = 3'h4;
  localparam int CNT_W = 23;
endpackage

/* File: bench/mssr_host_model.sv */
`timescale 1ns/1ps
module mssr_host_model (
  // clock
  input wire logic i_ref_clk,
  // register port toward the block
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  // in-band interrupt handshake
  input wire logic i_ibi_req,
  output logic o_ibi_done
);
  int ibi_dly = 0;
  int n_ibi = 0;
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
    o_ibi_done = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // clearing a flag means writing one to it; zeros leave others alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b0;
    o_reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1 d = i_reg_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // delivery delay varies so slow and prompt controllers are both seen
  always begin
    @(posedge i_ref_clk);
    if (i_ibi_req === 1'b1) begin
      repeat (ibi_dly) @(posedge i_ref_clk);
      o_ibi_done <= 1'b1;
      @(posedge i_ref_clk);
      o_ibi_done <= 1'b0;
      n_ibi++;
      @(posedge i_ref_clk);
    end
  end
endmodule

/* File: bench/tb_mssr_regs.sv */
`timescale 1ns/1ps
module tb_mssr_regs;
  import mssr_pkg::*;
  localparam int WS = 20;
  localparam int WL = 50;
  localparam int SH = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, wdt_to, ibi_req, ibi_done, int_out, int_oe;
  logic [3:0] odr = 4'h0;
  logic [1:0] avg = 2'h0;
  logic par = 1'b0;
  logic s01 = 1'b0;
  logic hdr = 1'b0;
  logic stall = 1'b0;
  logic drdy = 1'b0;
  logic [7:0] rdata_e;
  logic int_out_e, int_oe_e;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int n, n0;
  always #5 clk = ~clk;
  mssr_regs #(.WDT_SHORT(WS), .WDT_LONG(WL), .S0S1_HOLD(SH)) i_mssr_regs (
    .i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_eff_odr(odr), .i_eff_avg(avg), .i_parity_err(par),
    .i_s0s1_err(s01), .i_hdr_exit(hdr), .i_bus_stall(stall),
    .o_wdt_timeout(wdt_to), .i_drdy_event(drdy), .i_ibi_done(ibi_done),
    .o_ibi_req(ibi_req), .o_int_out(int_out), .o_int_oe(int_oe));
  // earliest revision: output gate reads reserved and stays open
  mssr_regs #(.WDT_SHORT(WS), .WDT_LONG(WL), .S0S1_HOLD(SH),
    .EARLY_REV(1'b1)) i_mssr_regs_early (
    .i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata_e),
    .i_eff_odr(odr), .i_eff_avg(avg), .i_parity_err(par),
    .i_s0s1_err(s01), .i_hdr_exit(hdr), .i_bus_stall(stall),
    .o_wdt_timeout(), .i_drdy_event(drdy), .i_ibi_done(ibi_done),
    .o_ibi_req(), .o_int_out(int_out_e), .o_int_oe(int_oe_e));
  mssr_host_model i_mssr_host_model (
    .i_ref_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_ibi_req(ibi_req),
    .o_ibi_done(ibi_done));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic rx(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_mssr_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wx(input logic [7:0] a, input logic [7:0] d);
    i_mssr_host_model.wr(a, d);
  endtask
  // one-cycle event pulse: 0 parity, 1 s0s1, 2 hdr exit, 3 data ready
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: par <= 1'b1;
      1: s01 <= 1'b1;
      2: hdr <= 1'b1;
      default: drdy <= 1'b1;
    endcase
    @(posedge clk);
    par <= 1'b0;
    s01 <= 1'b0;
    hdr <= 1'b0;
    drdy <= 1'b0;
  endtask
  // open-drain pin assumed to have a pull-up on the board
  function automatic logic pin_lvl();
    return int_oe ? int_out : 1'b1;
  endfunction
  task automatic pin_count(input logic pol, output int c);
    c = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (pin_lvl() === pol) c++;
    end
  endtask
  task automatic wdt_gap(output int g);
    int k;
    k = 0;
    g = 0;
    // measure only from the next timeout, so a period begun under the old setting is not counted
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (wdt_to !== 1'b1 && k < 200);
    do begin
      @(posedge clk);
      #1;
      g++;
    end while (wdt_to !== 1'b1 && g < 200);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] lv;
    void'($urandom(32'h99e9));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rx(OFS_RATE_AVG_STATUS, RST_BYTE);
    rx(OFS_BUS_ERROR_FLAGS, RST_BYTE);
    rx(OFS_BUS_WDT_CONFIG, RST_BYTE);
    rx(OFS_IRQ_PIN_CONFIG, RST_BYTE);
    rx(OFS_INBAND_IRQ_CONFIG, RST_BYTE);
    rx(OFS_IRQ_STATUS, RST_BYTE);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      odr <= 4'($urandom);
      avg <= 2'($urandom);
      wx(OFS_RATE_AVG_STATUS, 8'hFF);
      rx(OFS_RATE_AVG_STATUS, {2'b00, avg, odr});
    end
    // reserved bits must read back zero, unmapped offsets stay silent
    wx(OFS_BUS_WDT_CONFIG, 8'hFF);
    rx(OFS_BUS_WDT_CONFIG, 8'h03);
    wx(OFS_IRQ_PIN_CONFIG, 8'hFF);
    rx(OFS_IRQ_PIN_CONFIG, 8'h97);
    chk(rdata_e, 8'h87);
    wx(OFS_INBAND_IRQ_CONFIG, 8'hFF);
    rx(OFS_INBAND_IRQ_CONFIG, 8'h11);
    wx(8'h40, 8'hFF);
    rx(8'h40, 8'h00);
    wx(OFS_IRQ_PIN_CONFIG, 8'h00);
    wx(OFS_INBAND_IRQ_CONFIG, 8'h00);
    ev(0);
    rx(OFS_BUS_ERROR_FLAGS, 8'h01);
    rx(OFS_BUS_ERROR_FLAGS, 8'h00);
    ev(0);
    wx(OFS_BUS_ERROR_FLAGS, 8'h00);
    rx(OFS_BUS_ERROR_FLAGS, 8'h01);
    ev(0);
    ev(1);
    wx(OFS_BUS_ERROR_FLAGS, 8'h01);
    rx(OFS_BUS_ERROR_FLAGS, 8'h08);
    ev(1);
    repeat (SH - 5) @(posedge clk);
    rx(OFS_BUS_ERROR_FLAGS, 8'h08);
    ev(1);
    repeat (SH + 3) @(posedge clk);
    rx(OFS_BUS_ERROR_FLAGS, 8'h00);
    ev(1);
    ev(2);
    rx(OFS_BUS_ERROR_FLAGS, 8'h00);
    // watchdog: disabled, then short and long periods
    @(posedge clk);
    stall <= 1'b1;
    wx(OFS_BUS_WDT_CONFIG, 8'h00);
    wdt_gap(n);
    chk(n, 200);
    wx(OFS_BUS_WDT_CONFIG, 8'h01);
    wdt_gap(n);
    chk(n, WS);
    wx(OFS_BUS_WDT_CONFIG, 8'h03);
    wdt_gap(n);
    chk(n, WL);
    stall <= 1'b0;
    // every mode, polarity and driver combination of the pin
    for (int c = 0; c < 8; c++) begin
      wx(OFS_IRQ_PIN_CONFIG, 8'h90 | 8'(c));
      ev(3);
      pin_count(c[1], n);
      chk(n, c[0] ? 10 : 4);
      lv = {7'h00, c[0] ? c[1] : ~c[1]};
      chk({int_oe, int_out}, c[2] ? {1'b1, lv[0]} : {~lv[0], 1'b0});
      if (c[0]) begin
        wx(OFS_IRQ_STATUS, 8'h04);
      end
      rx(OFS_IRQ_STATUS, c[0] ? 8'h00 : 8'h04);
      pin_count(c[1], n);
      chk(n, 0);
    end
    wx(OFS_IRQ_PIN_CONFIG, 8'h81);
    ev(3);
    pin_count(1'b0, n);
    chk(n, 0);
    chk({int_oe_e, int_out_e}, 2'b10);
    rx(OFS_IRQ_STATUS, 8'h04);
    wx(OFS_IRQ_PIN_CONFIG, 8'h11);
    ev(3);
    pin_count(1'b0, n);
    chk(n, 0);
    rx(OFS_IRQ_STATUS, 8'h00);
    // in-band delivery: unmapped, mapped, mapped with auto-clear
    wx(OFS_IRQ_PIN_CONFIG, 8'h80);
    for (int k = 0; k < 3; k++) begin
      wx(OFS_INBAND_IRQ_CONFIG, k == 0 ? 8'h00 : (k == 1 ? 8'h01 : 8'h11));
      i_mssr_host_model.ibi_dly = $urandom_range(0, 5);
      n0 = i_mssr_host_model.n_ibi;
      ev(3);
      repeat (12) @(posedge clk);
      chk(i_mssr_host_model.n_ibi - n0, k == 0 ? 0 : 1);
      rx(OFS_IRQ_STATUS, k == 2 ? 8'h00 : 8'h04);
    end
    print_verdict();
  end
endmodule
